/* File: stm_map.svh */
/*
 Register offsets, field positions, reset values and timing constants
 for the 16-bit standard timer. Assumes inclusion by its bare name.
*/
`ifndef STM_MAP_SVH
`define STM_MAP_SVH

`define STM_OFS_CTRL_CLOCK   12'h000
`define STM_OFS_CTRL_MODE    12'h004
`define STM_OFS_CNT_LO       12'h008
`define STM_OFS_CNT_HI       12'h00c
`define STM_OFS_CMPA_LO      12'h010
`define STM_OFS_CMPA_HI      12'h014
`define STM_OFS_CMPP         12'h018
`define STM_OFS_STATUS       12'h01c
`define STM_OFS_CAPTURE      12'h020

`define STM_BIT_PAUSE        7
`define STM_BIT_RUN          3
`define STM_CTRL_CLOCK_MASK  8'hf8
`define STM_RESET_BYTE       8'h00
`define STM_STAT_A           0
`define STM_STAT_P           1

`define STM_DIV_SYS4         8'h03
`define STM_DIV_H16          8'h0f
`define STM_DIV_H64          8'h3f
`define STM_DIV_SUB          8'hff

`endif

/* File: stm_pkg.sv */
/*
 Types for the 16-bit standard timer.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package stm_pkg;
   typedef enum logic [1:0] {
      STM_MODE_COMPARE,
      STM_MODE_CAPTURE,
      STM_MODE_PWM,
      STM_MODE_TIMER
   } stm_mode_t;
endpackage : stm_pkg
`default_nettype wire

/* File: stm_timer.sv */
/*
 16-bit count-up timer with compare A, compare P, output, PWM, single
 pulse and capture functions, registers reached over APB.
 Assumes mclk at 20 MHz, synchronous inputs and an APB master.
*/
// Decided for this implementation: the APB slave port and the placing of the registers.
`include "stm_map.svh"
`default_nettype none

module stm_timer
   import stm_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        reset,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        ext_clock_pin,
   input  wire logic        timer_pin_first_in,
   input  wire logic        timer_pin_second_in,
   output logic             timer_pin_first,
   output logic             timer_pin_second,
   output logic             timer_out_en,
   output logic             match_a_flag,
   output logic             match_p_flag
);

   logic [7:0]  timer_control_clock;
   logic [7:0]  timer_control_mode;
   logic [15:0] counter;
   logic [15:0] compare_a_value;
   logic [7:0]  compare_p_value;
   logic [7:0]  prescale;
   logic        run_d;
   logic        ext_d;
   logic        cap_d;
   logic        out_level;
   logic        pwm_level;
   logic        tick;
   logic        run_rise;
   logic        wr_en;
   logic        rd_en;
   logic        addr_ok;
   logic        counting;
   logic        cnt_eq_a;
   logic        cnt_eq_p;
   logic        hit_a;
   logic        hit_p;
   logic        cap_edge;
   logic        pulse_end;
   logic        next_out;
   logic [15:0] next_counter;
   logic [31:0] next_rdata;
   stm_mode_t   mode;

   wire         counter_run      = timer_control_clock[`STM_BIT_RUN];
   wire         counter_pause    = timer_control_clock[`STM_BIT_PAUSE];
   wire         clock_sel_bit2   = timer_control_clock[6];
   wire  [2:0]  clock_sel        = timer_control_clock[6:4];
   wire         op_mode_sel_hi   = timer_control_mode[7];
   wire         op_mode_sel_lo   = timer_control_mode[6];
   wire         out_func_sel_hi  = timer_control_mode[5];
   wire         out_func_sel_lo  = timer_control_mode[4];
   wire         out_initial_level = timer_control_mode[3];
   wire         out_invert       = timer_control_mode[2];
   wire         period_duty_swap = timer_control_mode[1];
   wire         clear_source_sel = timer_control_mode[0];
   wire  [1:0]  out_func         = {out_func_sel_hi, out_func_sel_lo};

   function automatic logic apb_hit(input logic [11:0] a,
                                    input logic [11:0] ofs);
      apb_hit = (a == ofs);
   endfunction : apb_hit

   // Mode decode
   always_comb begin
      case ({op_mode_sel_hi, op_mode_sel_lo})
         2'b00:   mode = STM_MODE_COMPARE;
         2'b01:   mode = STM_MODE_CAPTURE;
         2'b10:   mode = STM_MODE_PWM;
         2'b11:   mode = STM_MODE_TIMER;
         default: mode = STM_MODE_COMPARE;
      endcase
   end

   assign pready   = 1'b1;
   assign wr_en    = psel & penable & pwrite;
   assign rd_en    = psel & ~pwrite;
   assign pslverr  = psel & penable & ~addr_ok;
   assign run_rise = counter_run & ~run_d;
   assign counting = counter_run & ~counter_pause;

   always_comb begin
      addr_ok = apb_hit(paddr, `STM_OFS_CTRL_CLOCK)
              | apb_hit(paddr, `STM_OFS_CTRL_MODE)
              | apb_hit(paddr, `STM_OFS_CNT_LO)
              | apb_hit(paddr, `STM_OFS_CNT_HI)
              | apb_hit(paddr, `STM_OFS_CMPA_LO)
              | apb_hit(paddr, `STM_OFS_CMPA_HI)
              | apb_hit(paddr, `STM_OFS_CMPP)
              | apb_hit(paddr, `STM_OFS_STATUS);
   end

   // Clock source selection
   always_comb begin
      case (clock_sel)
         3'b000:  tick = (prescale[1:0] == 2'(`STM_DIV_SYS4));
         3'b001:  tick = 1'b1;
         3'b010:  tick = (prescale[3:0] == 4'hf);
         3'b011:  tick = (prescale[5:0] == 6'h3f);
         3'b110:  tick = ext_clock_pin & ~ext_d;
         3'b111:  tick = ~ext_clock_pin & ext_d;
         default: tick = (prescale == `STM_DIV_SUB);
      endcase
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         prescale <= 8'h00;
         ext_d    <= 1'b0;
         run_d    <= 1'b0;
         cap_d    <= 1'b0;
      end else begin
         prescale <= prescale + 8'h01;
         ext_d    <= ext_clock_pin;
         run_d    <= counter_run;
         cap_d    <= timer_pin_first_in | timer_pin_second_in;
      end
   end

   // Comparators
   assign cnt_eq_a = (counter == compare_a_value) &&
                     (compare_a_value != 16'h0000);
   assign cnt_eq_p = (counter[15:8] == compare_p_value) &&
                     (compare_p_value != 8'h00) &&
                     (counter[7:0] == 8'h00);
   assign hit_a = counting & tick & (next_counter == compare_a_value) &
                  (compare_a_value != 16'h0000);
   assign hit_p = counting & tick & (compare_p_value != 8'h00) &
                  (next_counter == {compare_p_value, 8'h00});

   always_comb begin
      case (out_func)
         2'b00:   cap_edge = (timer_pin_first_in | timer_pin_second_in)
                             & ~cap_d;
         2'b01:   cap_edge = ~(timer_pin_first_in | timer_pin_second_in)
                             & cap_d;
         2'b10:   cap_edge = (timer_pin_first_in | timer_pin_second_in)
                             ^ cap_d;
         default: cap_edge = 1'b0;
      endcase
   end

   assign pulse_end = (mode == STM_MODE_PWM) && (out_func == 2'b11) &&
                      hit_a;

   // Counter
   always_comb begin
      next_counter = counter + 16'h0001;
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         counter <= 16'h0000;
      end else if (run_rise) begin
         counter <= 16'h0000;
      end else if (counting && tick) begin
         if (mode == STM_MODE_PWM) begin
            if (out_func == 2'b11) begin
               counter <= next_counter;
            end else if (period_duty_swap ? cnt_eq_a : cnt_eq_p) begin
               counter <= 16'h0000;
            end else begin
               counter <= next_counter;
            end
         end else if (mode != STM_MODE_CAPTURE && clear_source_sel) begin
            counter <= cnt_eq_a ? 16'h0000 : next_counter;
         end else begin
            counter <= cnt_eq_p ? 16'h0000 : next_counter;
         end
      end
   end

   // Registers and flags
   always_ff @(posedge mclk) begin
      if (reset) begin
         timer_control_clock <= `STM_RESET_BYTE;
         timer_control_mode  <= `STM_RESET_BYTE;
         compare_a_value     <= 16'h0000;
         compare_p_value     <= `STM_RESET_BYTE;
      end else begin
         if (wr_en && apb_hit(paddr, `STM_OFS_CTRL_CLOCK)) begin
            timer_control_clock <= pwdata[7:0] & `STM_CTRL_CLOCK_MASK;
         end else if (pulse_end) begin
            timer_control_clock[`STM_BIT_RUN] <= 1'b0;
         end else if (mode == STM_MODE_PWM && out_func == 2'b11 &&
                      tick && clock_sel_bit2 && clock_sel[1]) begin
            timer_control_clock[`STM_BIT_RUN] <= 1'b1;
         end
         if (wr_en && apb_hit(paddr, `STM_OFS_CTRL_MODE)) begin
            timer_control_mode <= pwdata[7:0];
         end
         if (mode == STM_MODE_CAPTURE && counter_run && cap_edge) begin
            compare_a_value <= counter;
         end else begin
            if (wr_en && apb_hit(paddr, `STM_OFS_CMPA_LO)) begin
               compare_a_value[7:0] <= pwdata[7:0];
            end
            if (wr_en && apb_hit(paddr, `STM_OFS_CMPA_HI)) begin
               compare_a_value[15:8] <= pwdata[7:0];
            end
         end
         if (wr_en && apb_hit(paddr, `STM_OFS_CMPP)) begin
            compare_p_value <= pwdata[7:0];
         end
      end
   end

   // Sticky flags: set wins over clear-by-writing-one
   always_ff @(posedge mclk) begin
      if (reset) begin
         match_a_flag <= 1'b0;
         match_p_flag <= 1'b0;
      end else begin
         if (hit_a || (mode == STM_MODE_CAPTURE && counter_run &&
                       cap_edge)) begin
            match_a_flag <= 1'b1;
         end else if (wr_en && apb_hit(paddr, `STM_OFS_STATUS) &&
                      pwdata[`STM_STAT_A]) begin
            match_a_flag <= 1'b0;
         end
         if (hit_p && !(mode != STM_MODE_PWM &&
                        mode != STM_MODE_CAPTURE &&
                        clear_source_sel)) begin
            match_p_flag <= 1'b1;
         end else if (wr_en && apb_hit(paddr, `STM_OFS_STATUS) &&
                      pwdata[`STM_STAT_P]) begin
            match_p_flag <= 1'b0;
         end
      end
   end

   // Compare output level
   always_comb begin
      next_out = out_level;
      case (out_func)
         2'b01:   next_out = 1'b0;
         2'b10:   next_out = 1'b1;
         2'b11:   next_out = ~out_level;
         default: next_out = out_level;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         out_level <= 1'b0;
      end else if (run_rise) begin
         out_level <= out_initial_level;
      end else if (mode == STM_MODE_COMPARE && hit_a) begin
         out_level <= next_out;
      end
   end

   // PWM and single pulse active state
   always_comb begin
      case (out_func)
         2'b00:   pwm_level = 1'b0;
         2'b01:   pwm_level = 1'b1;
         2'b10:   pwm_level = period_duty_swap ?
                     (counter < {compare_p_value, 8'h00} ||
                      compare_p_value == 8'h00) :
                     (counter < compare_a_value);
         default: pwm_level = counter_run;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         timer_pin_first  <= 1'b0;
         timer_pin_second <= 1'b0;
         timer_out_en     <= 1'b0;
      end else begin
         case (mode)
            STM_MODE_COMPARE: begin
               timer_pin_first  <= out_level ^ out_invert;
               timer_pin_second <= out_level ^ out_invert;
               timer_out_en     <= 1'b1;
            end
            STM_MODE_PWM: begin
               // Active level low when the initial-level bit is 0
               timer_pin_first  <= ~(pwm_level ^ out_initial_level)
                                   ^ out_invert;
               timer_pin_second <= ~(pwm_level ^ out_initial_level)
                                   ^ out_invert;
               timer_out_en     <= 1'b1;
            end
            default: begin
               timer_pin_first  <= 1'b0;
               timer_pin_second <= 1'b0;
               timer_out_en     <= 1'b0;
            end
         endcase
      end
   end

   // APB read data
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (paddr)
         `STM_OFS_CTRL_CLOCK: next_rdata[7:0] = timer_control_clock;
         `STM_OFS_CTRL_MODE:  next_rdata[7:0] = timer_control_mode;
         `STM_OFS_CNT_LO:     next_rdata[7:0] = counter[7:0];
         `STM_OFS_CNT_HI:     next_rdata[7:0] = counter[15:8];
         `STM_OFS_CMPA_LO:    next_rdata[7:0] = compare_a_value[7:0];
         `STM_OFS_CMPA_HI:    next_rdata[7:0] = compare_a_value[15:8];
         `STM_OFS_CMPP:       next_rdata[7:0] = compare_p_value;
         `STM_OFS_STATUS:     next_rdata[1:0] = {match_p_flag,
                                                 match_a_flag};
         default:             next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         prdata <= 32'h0000_0000;
      end else if (rd_en && !penable) begin
         prdata <= next_rdata;
      end
   end

endmodule : stm_timer
`default_nettype wire

/* File: stm_timer_assertions.sv */
/*
 Port-level checks of the timer: register bus answers and flag rules.
 Assumes a bind to stm_timer and one mclk domain.
*/
`default_nettype none
module stm_timer_assertions (
   input wire logic        mclk,
   input wire logic        reset,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        timer_pin_first,
   input wire logic        timer_out_en,
   input wire logic        match_a_flag,
   input wire logic        match_p_flag
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);
   logic       acc;
   logic       clr;
   logic [7:0] mode_q;
   logic [1:0] age_q;
   assign acc = psel && penable;
   assign clr = acc && pwrite && paddr == 12'h01c;
   // Mode byte as written, and cycles since the last write
   always_ff @(posedge mclk) begin
      if (reset)
         mode_q <= 8'h00;
      else if (acc && pwrite && paddr == 12'h004)
         mode_q <= pwdata[7:0];
   end
   always_ff @(posedge mclk) begin
      if (reset || (acc && pwrite))
         age_q <= 2'h0;
      else if (age_q != 2'h3)
         age_q <= age_q + 2'h1;
   end
   AST_CTRL_LOW_ZERO: assert property (
      acc && !pwrite && paddr == 12'h000 |-> prdata[2:0] == 3'h0)
      else $error("clock control low bits read nonzero");
   AST_BYTE_WIDE: assert property (
      acc && !pwrite |-> prdata[31:8] == 24'h00_0000)
      else $error("read data above the byte is nonzero");
   AST_UNMAPPED: assert property (
      acc && paddr > 12'h020 |-> pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
   AST_MAPPED: assert property (
      acc && paddr <= 12'h01c && paddr[1:0] == 2'h0 |-> pready && !pslverr)
      else $error("mapped access refused");
   AST_TIMER_IDLE: assert property (
      mode_q[7:6] == 2'h3 && age_q == 2'h3 |->
      !timer_out_en && !timer_pin_first)
      else $error("output active in timer mode");
   AST_A_STICKY: assert property (
      match_a_flag && !(clr && pwdata[0]) |=> match_a_flag)
      else $error("compare A flag lost");
   AST_P_STICKY: assert property (
      match_p_flag && !(clr && pwdata[1]) |=> match_p_flag)
      else $error("compare P flag lost");
   AST_NO_P_FLAG: assert property (
      mode_q[7:6] == 2'h0 && mode_q[0] && age_q == 2'h3 |->
      !$rose(match_p_flag))
      else $error("compare P flag raised while clearing on A");
   COV_UNMAPPED: cover property (acc && pslverr);
   COV_A_FLAG: cover property ($rose(match_a_flag));
   COV_P_FLAG: cover property ($rose(match_p_flag));
endmodule : stm_timer_assertions
bind stm_timer stm_timer_assertions u_chk (
   .mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .timer_pin_first(timer_pin_first),
   .timer_out_en(timer_out_en), .match_a_flag(match_a_flag),
   .match_p_flag(match_p_flag));
`default_nettype wire

/* File: stm_pin_model.sv */
/*
 Circuitry at the timer pins: external clock and two capture sources.
 Assumes the bench's mclk; all pins change just after its rising edge.
*/
`default_nettype none
module stm_pin_model (
   input  wire logic mclk,
   output logic      ext_clock_pin,
   output logic      cap_first,
   output logic      cap_second
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      ext_clock_pin = 1'b0;
      cap_first = 1'b0;
      cap_second = 1'b0;
   end
   // Each pulse is two mclk periods high, then two low
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge mclk);
         ext_clock_pin <= 1'b1;
         repeat (2) @(posedge mclk);
         ext_clock_pin <= 1'b0;
         @(posedge mclk);
      end
   endtask : pulses
   task automatic edge_to(input logic second, input logic v);
      @(posedge mclk);
      if (second)
         cap_second <= v;
      else
         cap_first <= v;
   endtask : edge_to
endmodule : stm_pin_model
`default_nettype wire

/* File: tb.sv */
/*
 Self-checking bench: APB tasks and register-level timer scenarios.
 Assumes stm_timer, its checker and the pin model are compiled first.
*/
`default_nettype none
module tb
   import stm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk = 1'b0;
   logic        reset = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready, pslverr, ext_clk, cap1, cap2, pin1, pin2, oen, fa, fp;
   logic [7:0]  rq, rx;
   logic [7:0]  go = 8'h18;
   logic        re, oc, pol;
   logic [1:0]  io;
   int          num_errors = 0;
   int          tests_run = 0;
   int          i, c;
   always #25 mclk = ~mclk;
   stm_timer dut (
      .mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ext_clock_pin(ext_clk),
      .timer_pin_first_in(cap1), .timer_pin_second_in(cap2),
      .timer_pin_first(pin1), .timer_pin_second(pin2),
      .timer_out_en(oen), .match_a_flag(fa), .match_p_flag(fp));
   stm_pin_model pins (.mclk(mclk), .ext_clock_pin(ext_clk),
      .cap_first(cap1), .cap_second(cap2));
   task automatic summarize;
      $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : summarize
   task automatic timeout;
      num_errors++;
      $display("wrong value at %0t: wait ran out", $time);
      summarize();
   endtask : timeout
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         num_errors++;
         $display("wrong value at %0t: saw %h, want %h", $time, s, e);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [7:0] d);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h00_0000, d};
      @(posedge mclk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge mclk);
         if (pready === 1'b1) break;
      end
      rq = prdata[7:0];
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 16) timeout();
   endtask : apb
   task automatic wait_for(input logic p, input int lim, output int n);
      for (n = 0; n < lim; n++) begin
         @(posedge mclk);
         if ((p ? fp : fa) === 1'b1) break;
      end
      if (n == lim) timeout();
   endtask : wait_for
   task automatic setup(input logic [7:0] c1, input logic [15:0] a,
                        input logic [7:0] p);
      apb(1'b1, 12'h000, 8'h10);
      apb(1'b1, 12'h004, c1);
      apb(1'b1, 12'h010, a[7:0]);
      apb(1'b1, 12'h014, a[15:8]);
      apb(1'b1, 12'h018, p);
      apb(1'b1, 12'h01c, 8'h03);
      apb(1'b1, 12'h000, go);
   endtask : setup
   // Counter low byte must not move after this control write
   task automatic frozen(input logic [7:0] ctl);
      apb(1'b1, 12'h000, ctl);
      apb(1'b0, 12'h008, 8'h00);
      rx = rq;
      repeat (9) @(posedge mclk);
      apb(1'b0, 12'h008, 8'h00);
      chk(rq, rx);
   endtask : frozen
   initial begin
      repeat (4) @(posedge mclk);
      reset <= 1'b0;
      for (i = 0; i < 8; i++) begin
         apb(1'b0, 12'(4 * i), 8'h00);
         chk(rq, 8'h00);
      end
      apb(1'b1, 12'h040, 8'hff);
      apb(1'b0, 12'h040, 8'h00);
      chk({re, rq}, 9'h100);
      apb(1'b1, 12'h000, 8'hff);
      apb(1'b0, 12'h000, 8'h00);
      chk(rq, 8'hf8);
      apb(1'b1, 12'h008, 8'h5a);
      apb(1'b0, 12'h008, 8'h00);
      chk(rq, 8'h00);
      apb(1'b1, 12'h010, 8'ha5);
      apb(1'b1, 12'h014, 8'h5a);
      apb(1'b0, 12'h010, 8'h00);
      chk(rq, 8'ha5);
      apb(1'b0, 12'h014, 8'h00);
      chk(rq, 8'h5a);
      for (i = 0; i < 16; i++) begin
         {pol, oc, io} = 4'(i);
         setup({STM_MODE_COMPARE, io, oc, pol, 2'h1}, 16'h0180, 8'h01);
         repeat (3) @(posedge mclk);
         chk(pin1, oc ^ pol);
         repeat (300) @(posedge mclk);
         chk(pin1, oc ^ pol);
         wait_for(1'b0, 200, c);
         chk(c > 74 && c < 92, 1'b1);
         repeat (2) @(posedge mclk);
         chk(pin1, pol ^ (^io ? io[1] : oc ^ io[0]));
         chk({pin2, fp}, {pin1, 1'b0});
         apb(1'b0, 12'h00c, 8'h00);
         chk(rq, 8'h00);
      end
      frozen(8'h10);
      apb(1'b1, 12'h000, 8'h18);
      frozen(8'h98);
      apb(1'b1, 12'h000, 8'h18);
      repeat (9) @(posedge mclk);
      apb(1'b0, 12'h008, 8'h00);
      chk(rq != rx, 1'b1);
      setup({STM_MODE_COMPARE, 6'h00}, 16'h0100, 8'h02);
      wait_for(1'b1, 600, c);
      chk(c > 500 && c < 520, 1'b1);
      apb(1'b0, 12'h01c, 8'h00);
      chk(rq, 8'h03);
      apb(1'b0, 12'h00c, 8'h00);
      chk(rq, 8'h00);
      apb(1'b1, 12'h01c, 8'h03);
      apb(1'b0, 12'h01c, 8'h00);
      chk(rq, 8'h00);
      for (i = 0; i < 4; i++) begin
         setup({2'(i), 6'h04}, 16'h0100, 8'h00);
         repeat (3) @(posedge mclk);
         chk(oen, i == 0 || i == 2);
      end
      chk(pin1, 1'b0);
      for (i = 0; i < 8; i++) begin
         {pol, oc, io} = {i[2:1], 1'b0, i[0]};
         setup({STM_MODE_PWM, io, oc, pol, 2'h0}, 16'h0040, 8'h01);
         repeat (4) @(posedge mclk);
         chk(pin1, pol ^ oc ^ !io[0]);
      end
      for (i = 0; i < 2; i++) begin
         setup({STM_MODE_PWM, 4'ha, i[0], 1'b0}, 16'h0040, 8'h01);
         repeat (100) @(posedge mclk);
         chk(pin1, i[0]);
      end
      for (i = 0; i < 4; i++) begin
         setup({STM_MODE_CAPTURE, 2'(i), 4'h0}, 16'h0000, 8'h00);
         pins.edge_to(i[0], 1'b1);
         repeat (6) @(posedge mclk);
         chk(fa, i == 0 || i == 2);
         apb(1'b1, 12'h01c, 8'h01);
         pins.edge_to(i[0], 1'b0);
         repeat (6) @(posedge mclk);
         chk(fa, i == 1 || i == 2);
      end
      for (i = 0; i < 2; i++) begin
         go = 8'(8'h68 + 8'h10 * i);
         setup({STM_MODE_TIMER, 6'h00}, 16'h8000, 8'h00);
         pins.pulses(5 + i);
         repeat (6) @(posedge mclk);
         apb(1'b0, 12'h008, 8'h00);
         chk(rq, 8'(5 + i));
      end
      // Divided clocks: a window of ten times the ratio holds ten ticks
      for (i = 0; i < 4; i++) begin
         go = {1'b0, ((i == 0) ? 3'h0 : 3'(i + 1)), 4'h8};
         setup({STM_MODE_TIMER, 6'h00}, 16'h8000, 8'h00);
         repeat (40 << (2 * i)) @(posedge mclk);
         apb(1'b0, 12'h008, 8'h00);
         chk(rq, 8'h0a);
      end
      go = 8'h18;
      setup({STM_MODE_PWM, 2'b11, 1'b1, 1'b0, 2'h0}, 16'h0040, 8'h00);
      repeat (20) @(posedge mclk);
      chk(pin1, 1'b1);
      repeat (100) @(posedge mclk);
      chk(pin1, 1'b0);
      chk(fa, 1'b1);
      apb(1'b0, 12'h000, 8'h00);
      chk(rq, 8'h10);
      // Compare values zero: one full 65536-clock wrap, no A flag
      setup({STM_MODE_TIMER, 6'h00}, 16'h0000, 8'h00);
      repeat (65540) @(posedge mclk);
      apb(1'b0, 12'h008, 8'h00);
      chk(rq, 8'h04);
      chk(fa, 1'b0);
      apb(1'b0, 12'h00c, 8'h00);
      chk(rq, 8'h00);
      summarize();
   end
endmodule : tb
`default_nettype wire
